// ==== core/wbt_pkg.sv ====
package wbt_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int COLUMN_WORDS = 16;
   localparam int RANGE_COUNT = 16;
   localparam int SECS_W = 27;
   localparam logic [SECS_W-1:0] SEC_PER_HOUR = 27'h0000E10;
   localparam logic [SECS_W-1:0] SEC_PER_MIN = 27'h000003C;
   localparam logic [3:0] LAST_COLUMN = 4'hF;
   localparam logic [4:0] LAST_TABLE_WORD = 5'h1F;

   typedef enum logic [2:0] {
      WBT_COLUMN_TO_WORD_OP = 3'b000,
      WBT_WORD_TO_COLUMN_OP = 3'b001,
      WBT_HMS_TO_SECONDS_OP = 3'b010,
      WBT_SECONDS_TO_HMS_OP = 3'b011,
      WBT_SET_BIT_COUNT_OP = 3'b100,
      WBT_RANGE_TABLE_COMPARE_OP = 3'b101
   } wbt_op_t;

   typedef enum logic [1:0] {
      WBT_ST_IDLE = 2'b00,
      WBT_ST_READ = 2'b01,
      WBT_ST_TAKE = 2'b10,
      WBT_ST_WRITE = 2'b11
   } wbt_state_t;

   typedef struct packed {
      logic start;
      wbt_op_t op;
      logic [ADDR_W-1:0] src_addr;
      logic [ADDR_W-1:0] dst_addr;
      logic [3:0] bit_sel;
      logic [DATA_W-1:0] value;
      logic [DATA_W-1:0] count;
   } wbt_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic [DATA_W-1:0] wdata;
   } wbt_mem_req_t;

   typedef struct packed {
      wbt_state_t state;
      wbt_cmd_t cmd;
      logic [DATA_W-1:0] idx;
      logic [DATA_W-1:0] acc;
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] hi;
      logic [DATA_W-1:0] lower;
      logic pre;
      wbt_mem_req_t mem;
      logic busy;
      logic done;
   } wbt_state_reg_t;

endpackage

// ==== core/wbt_unit.sv ====
`timescale 1ns/100ps

// Behaviour
// - column op reads bit from 16 words
// - first source word lands in bit 00
// - word op spreads bits over 16 words
// - source bit 00 to first destination word
// - hms pair converted to seconds pair
// - seconds pair converted to hms pair
// - total set bits written to result word
// - scan exactly the given word count
// - compare value against 16 table ranges
// - in-range sets matching result bit
module wbt_unit (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire wbt_pkg::wbt_cmd_t cmd_i,
   input wire logic [wbt_pkg::DATA_W-1:0] mem_rdata_i,
   output wbt_pkg::wbt_mem_req_t mem_o,
   output logic busy_o,
   output logic done_o
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [wbt_pkg::SECS_W-1:0] bcd_to_bin(input logic [31:0] b);
      logic [wbt_pkg::SECS_W-1:0] r;
      r = '0;
      for (int i = 7; i >= 0; i--) begin
         r = wbt_pkg::SECS_W'(r * 27'h000000A) + wbt_pkg::SECS_W'(b[i*4 +: 4]);
      end
      return r;
   endfunction

   // shift-add-3; digits above 9 cannot arise for values below 10^8
   function automatic logic [31:0] bin_to_bcd(input logic [wbt_pkg::SECS_W-1:0] v);
      logic [31:0] d;
      d = '0;
      for (int i = wbt_pkg::SECS_W - 1; i >= 0; i--) begin
         for (int j = 0; j < 8; j++) begin
            if (d[j*4 +: 4] >= 4'h5) begin
               d[j*4 +: 4] = 4'(d[j*4 +: 4] + 4'h3);
            end
         end
         d = {d[30:0], v[i]};
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   wbt_pkg::wbt_state_reg_t st_reg;
   wbt_pkg::wbt_state_reg_t st_next;
   logic col_bit;
   logic range_hit;
   logic [wbt_pkg::SECS_W-1:0] hms_secs;
   logic [wbt_pkg::SECS_W-1:0] sth_secs;
   logic [wbt_pkg::SECS_W-1:0] sth_hours;
   logic [wbt_pkg::SECS_W-1:0] sth_rem;
   logic [31:0] hts_bcd;
   logic [31:0] hour_bcd;
   logic [31:0] min_bcd;
   logic [31:0] sec_bcd;
   localparam int DATA_W_CNT = wbt_pkg::DATA_W;

   assign col_bit = mem_rdata_i[st_reg.cmd.bit_sel];
   // lower limit was taken on the previous table word of this pair
   assign range_hit = (st_reg.lower <= st_reg.cmd.value) && (mem_rdata_i >= st_reg.cmd.value);

   // time words: low word is MMSS, high word is hours, all BCD
   assign hms_secs = wbt_pkg::SECS_W'(bcd_to_bin({16'h0000, mem_rdata_i}) * wbt_pkg::SEC_PER_HOUR)
      + wbt_pkg::SECS_W'(bcd_to_bin({24'h000000, st_reg.lo[15:8]}) * wbt_pkg::SEC_PER_MIN)
      + bcd_to_bin({24'h000000, st_reg.lo[7:0]});
   assign hts_bcd = bin_to_bcd(hms_secs);
   assign sth_secs = bcd_to_bin({mem_rdata_i, st_reg.lo});
   assign sth_hours = sth_secs / wbt_pkg::SEC_PER_HOUR;
   assign sth_rem = sth_secs % wbt_pkg::SEC_PER_HOUR;
   assign hour_bcd = bin_to_bcd(sth_hours);
   assign min_bcd = bin_to_bcd(sth_rem / wbt_pkg::SEC_PER_MIN);
   assign sec_bcd = bin_to_bcd(sth_rem % wbt_pkg::SEC_PER_MIN);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.mem.rd = 1'b0;
      st_next.mem.wr = 1'b0;
      case (st_reg.state)
         wbt_pkg::WBT_ST_IDLE: begin
            if (cmd_i.start && (cmd_i.op <= wbt_pkg::WBT_RANGE_TABLE_COMPARE_OP)) begin
               st_next.cmd = cmd_i;
               st_next.idx = '0;
               st_next.acc = '0;
               st_next.lo = '0;
               st_next.pre = (cmd_i.op == wbt_pkg::WBT_WORD_TO_COLUMN_OP);
               st_next.busy = 1'b1;
               if ((cmd_i.op == wbt_pkg::WBT_SET_BIT_COUNT_OP) && (cmd_i.count == '0)) begin
                  st_next.state = wbt_pkg::WBT_ST_WRITE;
                  st_next.mem.wr = 1'b1;
                  st_next.mem.addr = cmd_i.dst_addr;
                  st_next.mem.wdata = '0;
               end else begin
                  st_next.state = wbt_pkg::WBT_ST_READ;
                  st_next.mem.rd = 1'b1;
                  st_next.mem.addr = cmd_i.src_addr;
               end
            end
         end
         wbt_pkg::WBT_ST_READ: begin
            st_next.state = wbt_pkg::WBT_ST_TAKE;
         end
         wbt_pkg::WBT_ST_TAKE: begin
            st_next.state = wbt_pkg::WBT_ST_READ;
            st_next.mem.rd = 1'b1;
            st_next.idx = st_reg.idx + 16'h0001;
            st_next.mem.addr = st_reg.cmd.src_addr + st_next.idx;
            case (st_reg.cmd.op)
               wbt_pkg::WBT_COLUMN_TO_WORD_OP: begin
                  st_next.acc[st_reg.idx[3:0]] = col_bit;
                  if (st_reg.idx[3:0] == wbt_pkg::LAST_COLUMN) begin
                     st_next.idx = st_reg.idx;
                     st_next.state = wbt_pkg::WBT_ST_WRITE;
                     st_next.mem.rd = 1'b0;
                     st_next.mem.wr = 1'b1;
                     st_next.mem.addr = st_reg.cmd.dst_addr;
                     st_next.mem.wdata = st_next.acc;
                  end
               end
               wbt_pkg::WBT_WORD_TO_COLUMN_OP: begin
                  if (st_reg.pre) begin
                     st_next.pre = 1'b0;
                     st_next.acc = mem_rdata_i;
                     st_next.idx = st_reg.idx;
                     st_next.mem.addr = st_reg.cmd.dst_addr;
                  end else begin
                     // read-modify-write keeps the other fifteen bits of each word
                     st_next.idx = st_reg.idx;
                     st_next.state = wbt_pkg::WBT_ST_WRITE;
                     st_next.mem.rd = 1'b0;
                     st_next.mem.wr = 1'b1;
                     st_next.mem.addr = st_reg.cmd.dst_addr + st_reg.idx;
                     st_next.mem.wdata = mem_rdata_i;
                     st_next.mem.wdata[st_reg.cmd.bit_sel] = st_reg.acc[st_reg.idx[3:0]];
                  end
               end
               wbt_pkg::WBT_HMS_TO_SECONDS_OP, wbt_pkg::WBT_SECONDS_TO_HMS_OP: begin
                  if (st_reg.idx == '0) begin
                     st_next.lo = mem_rdata_i;
                  end else begin
                     st_next.state = wbt_pkg::WBT_ST_WRITE;
                     st_next.mem.rd = 1'b0;
                     st_next.mem.wr = 1'b1;
                     st_next.mem.addr = st_reg.cmd.dst_addr;
                     st_next.pre = 1'b1;
                     if (st_reg.cmd.op == wbt_pkg::WBT_HMS_TO_SECONDS_OP) begin
                        st_next.lo = hts_bcd[15:0];
                        st_next.hi = hts_bcd[31:16];
                     end else begin
                        st_next.lo = {min_bcd[7:0], sec_bcd[7:0]};
                        st_next.hi = hour_bcd[15:0];
                     end
                     st_next.mem.wdata = st_next.lo;
                  end
               end
               wbt_pkg::WBT_SET_BIT_COUNT_OP: begin
                  st_next.acc = st_reg.acc + DATA_W_CNT'($countones(mem_rdata_i));
                  if (st_next.idx == st_reg.cmd.count) begin
                     st_next.state = wbt_pkg::WBT_ST_WRITE;
                     st_next.mem.rd = 1'b0;
                     st_next.mem.wr = 1'b1;
                     st_next.mem.addr = st_reg.cmd.dst_addr;
                     st_next.mem.wdata = st_next.acc;
                  end
               end
               default: begin
                  // range k: lower at start+2k, upper at start+2k+1
                  if (!st_reg.idx[0]) begin
                     st_next.lower = mem_rdata_i;
                  end else begin
                     st_next.acc[st_reg.idx[4:1]] = range_hit;
                  end
                  if (st_reg.idx[4:0] == wbt_pkg::LAST_TABLE_WORD) begin
                     st_next.idx = st_reg.idx;
                     st_next.state = wbt_pkg::WBT_ST_WRITE;
                     st_next.mem.rd = 1'b0;
                     st_next.mem.wr = 1'b1;
                     st_next.mem.addr = st_reg.cmd.dst_addr;
                     st_next.mem.wdata = st_next.acc;
                  end
               end
            endcase
         end
         default: begin
            st_next.state = wbt_pkg::WBT_ST_IDLE;
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            if ((st_reg.cmd.op == wbt_pkg::WBT_WORD_TO_COLUMN_OP)
                  && (st_reg.idx[3:0] != wbt_pkg::LAST_COLUMN)) begin
               st_next.idx = st_reg.idx + 16'h0001;
               st_next.state = wbt_pkg::WBT_ST_READ;
               st_next.mem.rd = 1'b1;
               st_next.mem.addr = st_reg.cmd.dst_addr + st_next.idx;
               st_next.busy = 1'b1;
               st_next.done = 1'b0;
            end else if (st_reg.pre) begin
               st_next.pre = 1'b0;
               st_next.state = wbt_pkg::WBT_ST_WRITE;
               st_next.mem.wr = 1'b1;
               st_next.mem.addr = st_reg.cmd.dst_addr + 16'h0001;
               st_next.mem.wdata = st_reg.hi;
               st_next.busy = 1'b1;
               st_next.done = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign mem_o = st_reg.mem;
   assign busy_o = st_reg.busy;
   assign done_o = st_reg.done;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [3:0] take_col;
   logic [3:0] take_range;
   logic take_ctw;
   logic take_odd_cmp;
   assign take_col = st_reg.idx[3:0];
   assign take_range = st_reg.idx[4:1];
   assign take_ctw = (st_reg.state == wbt_pkg::WBT_ST_TAKE)
      && (st_reg.cmd.op == wbt_pkg::WBT_COLUMN_TO_WORD_OP);
   assign take_odd_cmp = (st_reg.state == wbt_pkg::WBT_ST_TAKE) && st_reg.idx[0]
      && (st_reg.cmd.op == wbt_pkg::WBT_RANGE_TABLE_COMPARE_OP);

   sequence read_then_take_s;
      mem_o.rd ##1 (st_reg.state == wbt_pkg::WBT_ST_TAKE);
   endsequence

   sequence idle_start_s;
      (st_reg.state == wbt_pkg::WBT_ST_IDLE) && cmd_i.start
         && (cmd_i.op == wbt_pkg::WBT_COLUMN_TO_WORD_OP);
   endsequence

   first_src_read_a: assert property (idle_start_s |=> busy_o && mem_o.rd
      && (mem_o.addr == $past(cmd_i.src_addr)))
      else $error("column op did not read first source word");
   read_pipeline_a: assert property (mem_o.rd |-> read_then_take_s)
      else $error("read not followed by capture");
   ctw_gather_a: assert property (take_ctw |=> st_reg.acc[$past(take_col)] == $past(col_bit))
      else $error("column bit placed in wrong result bit");
   wtc_bit_a: assert property (mem_o.wr && (st_reg.cmd.op == wbt_pkg::WBT_WORD_TO_COLUMN_OP)
      |-> mem_o.wdata[st_reg.cmd.bit_sel] == st_reg.acc[take_col])
      else $error("scattered bit mismatch");
   wtc_addr_a: assert property (mem_o.wr && (st_reg.cmd.op == wbt_pkg::WBT_WORD_TO_COLUMN_OP)
      |-> mem_o.addr == (st_reg.cmd.dst_addr + st_reg.idx))
      else $error("scatter write address wrong");
   set_bit_count_op_len_a: assert property (mem_o.wr && (st_reg.cmd.op == wbt_pkg::WBT_SET_BIT_COUNT_OP)
      |-> st_reg.idx == st_reg.cmd.count)
      else $error("bit count scanned wrong number of words");
   set_bit_count_op_sum_a: assert property ((st_reg.state == wbt_pkg::WBT_ST_TAKE)
      && (st_reg.cmd.op == wbt_pkg::WBT_SET_BIT_COUNT_OP)
      |=> st_reg.acc == 16'($past(st_reg.acc) + 16'($countones($past(mem_rdata_i)))))
      else $error("bit count total wrong");
   range_bit_a: assert property (take_odd_cmp |=> st_reg.acc[$past(take_range)]
      == $past(range_hit))
      else $error("range result bit wrong");
   done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
      else $error("done not a single pulse");

endmodule // wbt_unit

// ==== core/dummy_unused_none.sv ====
`timescale 1ns/100ps

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   typedef struct {
      logic [2:0] op;
      logic [15:0] src;
      logic [15:0] dst;
      logic [3:0] bsel;
      logic [15:0] val;
      logic [15:0] cnt;
      logic [15:0] w1;
   } wbt_row_t;
   logic core_clk_i;
   logic rst_n_i;
   wbt_pkg::wbt_cmd_t cmd_i;
   logic [15:0] mem_rdata_i = 16'h0000;
   logic rd_q = 1'b0;
   logic [7:0] rd_addr_q = 8'h00;
   wbt_pkg::wbt_mem_req_t mem_o;
   logic busy_o;
   logic done_o;
   logic [15:0] mem [0:255];
   logic [15:0] ref_mem [0:255];
   int n_mismatch = 0;
   int compares = 0;
   // time ops: val is the low word, w1 the high word, all BCD inside one area
   wbt_row_t rows [12] = '{
      '{3'h0, 16'h0010, 16'h0080, 4'h5, 16'h0000, 16'h0000, 16'h0000},
      '{3'h0, 16'h0020, 16'h0081, 4'hF, 16'h0000, 16'h0000, 16'h0000},
      '{3'h1, 16'h0030, 16'h0040, 4'h0, 16'hA5C3, 16'h0000, 16'h0000},
      '{3'h1, 16'h0031, 16'h0050, 4'hF, 16'h8001, 16'h0000, 16'h0000},
      '{3'h2, 16'h0060, 16'h0090, 4'h0, 16'h5959, 16'h0000, 16'h9999},
      '{3'h2, 16'h0060, 16'h0094, 4'h0, 16'h0130, 16'h0000, 16'h0002},
      '{3'h3, 16'h0062, 16'h0096, 4'h0, 16'h9999, 16'h0000, 16'h3599},
      '{3'h3, 16'h0062, 16'h0098, 4'h0, 16'h3661, 16'h0000, 16'h0000},
      '{3'h4, 16'h0010, 16'h0092, 4'h0, 16'h0000, 16'h0005, 16'h0000},
      '{3'h4, 16'h0010, 16'h0093, 4'h0, 16'h0000, 16'h0000, 16'h0000},
      '{3'h5, 16'h00A0, 16'h009A, 4'h0, 16'h0500, 16'h0000, 16'h0000},
      '{3'h5, 16'h00A0, 16'h009B, 4'h0, 16'h06FF, 16'h0000, 16'h0000}
   };

   wbt_unit dut (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .cmd_i(cmd_i),
      .mem_rdata_i(mem_rdata_i),
      .mem_o(mem_o),
      .busy_o(busy_o),
      .done_o(done_o)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data is valid only in the cycle after rd; otherwise it toggles so stale data shows
   // the request is remembered one cycle so the data stands in the capture cycle
   always @(negedge core_clk_i) begin
      if (mem_o.wr) mem[mem_o.addr[7:0]] = mem_o.wdata;
      if (rd_q) mem_rdata_i <= mem[rd_addr_q];
      else mem_rdata_i <= ~mem_rdata_i;
      rd_q <= mem_o.rd;
      rd_addr_q <= mem_o.addr[7:0];
   end

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic int bcd_val(logic [31:0] b);
      int v = 0;
      for (int i = 7; i >= 0; i--) v = v * 10 + int'(b[i*4 +: 4]);
      return v;
   endfunction

   function automatic logic [31:0] to_bcd(int v);
      logic [31:0] b = '0;
      for (int i = 0; i < 8; i++) begin
         b[i*4 +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // the whole memory is predicted, so stray writes are caught as well
   task automatic predict(wbt_row_t r, output int lat);
      int t;
      logic [15:0] w;
      logic [31:0] b;
      for (int i = 0; i < 256; i++) ref_mem[i] = mem[i];
      case (r.op)
         3'h0: begin
            for (int j = 0; j < 16; j++) w[j] = mem[8'(r.src + j)][r.bsel];
            ref_mem[8'(r.dst)] = w;
            lat = 34;
         end
         3'h1: begin
            for (int j = 0; j < 16; j++) ref_mem[8'(r.dst + j)][r.bsel] = r.val[j];
            lat = 51;
         end
         3'h2: begin
            t = bcd_val(32'(r.w1)) * 3600 + bcd_val(32'(r.val[15:8])) * 60;
            b = to_bcd(t + bcd_val(32'(r.val[7:0])));
            ref_mem[8'(r.dst)] = b[15:0];
            ref_mem[8'(r.dst + 1)] = b[31:16];
            lat = 7;
         end
         3'h3: begin
            t = bcd_val({r.w1, r.val});
            b = to_bcd((t / 60 % 60) * 100 + t % 60);
            ref_mem[8'(r.dst)] = b[15:0];
            b = to_bcd(t / 3600);
            ref_mem[8'(r.dst + 1)] = b[15:0];
            lat = 7;
         end
         3'h4: begin
            t = 0;
            for (int j = 0; j < int'(r.cnt); j++) t += $countones(mem[8'(r.src + j)]);
            ref_mem[8'(r.dst)] = 16'(t);
            lat = 2 * int'(r.cnt) + 2;
         end
         default: begin
            for (int k = 0; k < 16; k++) begin
               w[k] = mem[8'(r.src + 2 * k)] <= r.val && r.val <= mem[8'(r.src + 2 * k + 1)];
            end
            ref_mem[8'(r.dst)] = w;
            lat = 66;
         end
      endcase
   endtask

   // poke re-presents a start mid-run, which must be ignored while busy
   task automatic run(wbt_row_t r, bit poke);
      int cyc;
      int lat;
      if (r.op inside {3'h1, 3'h2, 3'h3}) begin
         mem[8'(r.src)] = r.val;
         mem[8'(r.src + 1)] = r.w1;
      end
      predict(r, lat);
      cmd_i = '{1'b1, wbt_pkg::wbt_op_t'(r.op), r.src, r.dst, r.bsel, r.val, r.cnt};
      @(negedge core_clk_i);
      cmd_i.start = 1'b0;
      cyc = 1;
      check("busy", 32'h1, 32'(busy_o));
      while (done_o !== 1'b1) begin
         @(negedge core_clk_i);
         cyc++;
         if (poke) begin
            cmd_i.start = (cyc == 2);
            cmd_i.op = wbt_pkg::WBT_HMS_TO_SECONDS_OP;
         end
         if (cyc >= 200) begin
            n_mismatch++;
            close_out();
         end
      end
      check("latency", 32'(lat), 32'(cyc));
      for (int i = 0; i < 256; i++) begin
         check($sformatf("mem %0d", i), 32'(ref_mem[i]), 32'(mem[i]));
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      cmd_i = '0;
      for (int i = 0; i < 256; i++) mem[i] = 16'(i * 40503 + 4660);
      for (int k = 0; k < 16; k++) begin
         mem[8'(160 + 2 * k)] = 16'(k * 256);
         mem[8'(161 + 2 * k)] = 16'(k * 256 + 511);
      end
      mem[8'hBE] = 16'hFFFF;
      mem[8'hBF] = 16'h0000;
      repeat (16) @(negedge core_clk_i);
      check("reset outputs", 32'h0, 32'({busy_o, done_o, mem_o.rd, mem_o.wr}));
      rst_n_i = 1'b1;
      foreach (rows[i]) run(rows[i], 1'b0);
      run(rows[8], 1'b1);
      for (int op = 6; op < 8; op++) begin
         cmd_i.op = wbt_pkg::wbt_op_t'(op);
         cmd_i.start = 1'b1;
         repeat (3) @(negedge core_clk_i);
         check("unused op", 32'h0, 32'({busy_o, done_o, mem_o.rd, mem_o.wr}));
         cmd_i.start = 1'b0;
         @(negedge core_clk_i);
      end
      cmd_i = '{1'b1, wbt_pkg::WBT_COLUMN_TO_WORD_OP, 16'h0010, 16'h0082, 4'h1, 16'h0, 16'h0};
      @(negedge core_clk_i);
      cmd_i.start = 1'b0;
      repeat (5) @(negedge core_clk_i);
      rst_n_i = 1'b0;
      @(negedge core_clk_i);
      check("abort outputs", 32'h0, 32'({busy_o, done_o, mem_o.rd, mem_o.wr}));
      rst_n_i = 1'b1;
      run(rows[9], 1'b0);
      run(rows[0], 1'b0);
      close_out();
   end
endmodule // tb_top
